/* core/mmpm_top.sv */
// Power mode controller of the magnetometer part
`timescale 1ns/1ps
`include "mmpm_map.svh"
module mmpm_top #(
   parameter int STARTUP_CYC = `MMPM_T_STARTUP_NS / `MMPM_CLK_NS,
   parameter int PLANAR_CYC = `MMPM_T_PLANAR_NS / `MMPM_CLK_NS,
   parameter int VERTICAL_CYC = `MMPM_T_VERTICAL_NS / `MMPM_CLK_NS,
   parameter int BASE_CYC = `MMPM_T_BASE_NS / `MMPM_CLK_NS,
   parameter int RATE_UNIT_CYC = `MMPM_T_RATE_UNIT_NS / `MMPM_CLK_NS,
   // Arbitrary identity value
   parameter logic [7:0] IDENTITY = `MMPM_IDENTITY_VAL
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_reset,
   // Supplies and protocol
   input wire logic i_core_supply_ok,
   input wire logic i_io_supply_ok,
   input wire logic i_spi_mode,
   input wire logic [7:0] i_nvm_trim,
   // Register access
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   output logic o_rd_valid,
   output logic [7:0] o_rd_data,
   output logic o_rd_drive,
   // Sensor front end
   input wire logic [12:0] i_field_x,
   input wire logic [12:0] i_field_y,
   input wire logic [14:0] i_field_z,
   input wire logic [13:0] i_plate_res,
   // Status
   output mmpm_pkg::mmpm_state_t o_state,
   output logic o_spi3_wire
);
   import mmpm_pkg::*;

   mmpm_state_t state;
   mmpm_state_t next_state;
   logic [7:0] power_control;
   logic [7:0] next_power_control;
   logic [7:0] operation_select;
   logic [7:0] next_operation_select;
   logic [7:0] planar_repeats;
   logic [7:0] next_planar_repeats;
   logic [7:0] vertical_repeats;
   logic [7:0] next_vertical_repeats;
   logic [7:0] trim;
   logic [7:0] next_trim;
   logic [12:0] first_axis_result;
   logic [12:0] next_first_axis_result;
   logic [12:0] second_axis_result;
   logic [12:0] next_second_axis_result;
   logic [14:0] third_axis_result;
   logic [14:0] next_third_axis_result;
   logic [13:0] plate_resistance_result;
   logic [13:0] next_plate_resistance_result;
   logic [31:0] cnt;
   logic [31:0] next_cnt;
   logic next_rd_valid;
   logic [7:0] next_rd_data;
   logic next_rd_drive;
   logic meas_start;
   logic meas_stop;
   logic meas_busy;
   logic meas_done;
   logic supplies_ok;
   logic access_ok;
   logic wr_ok;
   logic active;
   logic [1:0] wr_mode;
   logic [31:0] period_lim;

   // ----------------------------------------
   // Measurement timer
   // ----------------------------------------
   mmpm_meas #(
      .PLANAR_CYC(PLANAR_CYC),
      .VERTICAL_CYC(VERTICAL_CYC),
      .BASE_CYC(BASE_CYC)
   ) u_meas (
      .i_mclk(i_mclk),
      .i_reset(i_reset),
      .i_start(meas_start),
      .i_stop(meas_stop),
      .i_planar(planar_repeats),
      .i_vertical(vertical_repeats),
      .o_busy(meas_busy),
      .o_done(meas_done)
   );

   // ----------------------------------------
   // Register read mux
   // ----------------------------------------
   function automatic logic [7:0] read_mux(input logic [7:0] addr);
      case (addr)
         `MMPM_ADDR_IDENTITY: read_mux = IDENTITY;
         `MMPM_ADDR_X_LO: read_mux = {first_axis_result[4:0], 3'h0};
         `MMPM_ADDR_X_HI: read_mux = first_axis_result[12:5];
         `MMPM_ADDR_Y_LO: read_mux = {second_axis_result[4:0], 3'h0};
         `MMPM_ADDR_Y_HI: read_mux = second_axis_result[12:5];
         `MMPM_ADDR_Z_LO: read_mux = {third_axis_result[6:0], 1'h0};
         `MMPM_ADDR_Z_HI: read_mux = third_axis_result[14:7];
         `MMPM_ADDR_R_LO: read_mux = {plate_resistance_result[5:0], 2'h0};
         `MMPM_ADDR_R_HI: read_mux = plate_resistance_result[13:6];
         `MMPM_ADDR_POWER: read_mux = power_control;
         `MMPM_ADDR_OPSEL: read_mux = operation_select;
         `MMPM_ADDR_PLANAR: read_mux = planar_repeats;
         `MMPM_ADDR_VERTICAL: read_mux = vertical_repeats;
         `MMPM_ADDR_TRIM: read_mux = trim;
         default: read_mux = 8'h00;
      endcase
   endfunction

   // ----------------------------------------
   // Next state and registers
   // ----------------------------------------
   always_comb begin
      supplies_ok = i_core_supply_ok && i_io_supply_ok;
      active = (state == MMPM_NORMAL) || (state == MMPM_FORCED);
      wr_mode = i_reg_wdata[`MMPM_MODE_MSB:`MMPM_MODE_LSB];
      period_lim = 32'(RATE_UNIT_CYC)
                 * (32'h00000008 - {29'h0, operation_select[`MMPM_RATE_MSB:`MMPM_RATE_LSB]});
      case (state)
         MMPM_SUSPEND: access_ok = (i_reg_addr == `MMPM_ADDR_POWER);
         MMPM_SLEEP, MMPM_NORMAL, MMPM_FORCED: access_ok = 1'b1;
         default: access_ok = 1'b0;
      endcase
      wr_ok = i_reg_wr && access_ok;
      next_state = state;
      next_power_control = power_control;
      next_operation_select = operation_select;
      next_planar_repeats = planar_repeats;
      next_vertical_repeats = vertical_repeats;
      next_trim = trim;
      next_first_axis_result = first_axis_result;
      next_second_axis_result = second_axis_result;
      next_third_axis_result = third_axis_result;
      next_plate_resistance_result = plate_resistance_result;
      next_cnt = cnt;
      meas_start = 1'b0;
      meas_stop = 1'b0;
      // Plain register writes
      if (wr_ok) begin
         case (i_reg_addr)
            `MMPM_ADDR_POWER: next_power_control = i_reg_wdata & 8'h7F;
            `MMPM_ADDR_OPSEL: next_operation_select = i_reg_wdata;
            `MMPM_ADDR_PLANAR: next_planar_repeats = i_reg_wdata;
            `MMPM_ADDR_VERTICAL: next_vertical_repeats = i_reg_wdata;
            default: next_state = state;
         endcase
      end
      // Results land as one set
      if (meas_done && active) begin
         next_first_axis_result = i_field_x;
         next_second_axis_result = i_field_y;
         next_third_axis_result = i_field_z;
         next_plate_resistance_result = i_plate_res;
      end
      case (state)
         MMPM_POWER_OFF: begin
            next_cnt = 32'h00000000;
            if (supplies_ok) begin
               next_state = MMPM_STARTUP;
            end
         end
         MMPM_STARTUP: begin
            next_cnt = cnt + 32'h00000001;
            if (cnt == 32'(STARTUP_CYC - 1)) begin
               next_trim = i_nvm_trim;
               next_state = MMPM_SUSPEND;
            end
         end
         MMPM_SUSPEND: begin
            if (wr_ok && i_reg_wdata[`MMPM_PWR_BIT]) begin
               next_state = MMPM_SLEEP;
            end
         end
         MMPM_SLEEP: begin
            if (wr_ok && i_reg_addr == `MMPM_ADDR_OPSEL) begin
               if (wr_mode == MMPM_MODE_NORMAL) begin
                  next_state = MMPM_NORMAL;
                  next_cnt = 32'h00000000;
                  meas_start = 1'b1;
               end else if (wr_mode == MMPM_MODE_FORCED) begin
                  next_state = MMPM_FORCED;
                  meas_start = 1'b1;
               end
            end
         end
         MMPM_NORMAL: begin
            next_cnt = cnt + 32'h00000001;
            if (cnt >= period_lim - 32'h00000001) begin
               next_cnt = 32'h00000000;
               meas_start = 1'b1;
            end
            if (wr_ok && i_reg_addr == `MMPM_ADDR_OPSEL && wr_mode == MMPM_MODE_SLEEP) begin
               next_state = MMPM_SLEEP;
            end
         end
         MMPM_FORCED: begin
            if (meas_done) begin
               next_operation_select[`MMPM_MODE_MSB:`MMPM_MODE_LSB] = MMPM_MODE_SLEEP;
               next_state = MMPM_SLEEP;
            end
            if (wr_ok && i_reg_addr == `MMPM_ADDR_OPSEL) begin
               if (wr_mode == MMPM_MODE_SLEEP) begin
                  next_state = MMPM_SLEEP;
               end else if (wr_mode == MMPM_MODE_FORCED) begin
                  next_state = MMPM_FORCED;
                  meas_start = 1'b1;
               end
            end
         end
         default: next_state = MMPM_POWER_OFF;
      endcase
      // Soft reset: defaults, back to sleep
      if (wr_ok && i_reg_addr == `MMPM_ADDR_POWER && i_reg_wdata[`MMPM_SOFTRST_BIT]
          && i_reg_wdata[`MMPM_PWR_BIT] && state != MMPM_SUSPEND) begin
         next_state = MMPM_SLEEP;
         next_operation_select = `MMPM_OPSEL_RST;
         next_planar_repeats = `MMPM_REPEAT_RST;
         next_vertical_repeats = `MMPM_REPEAT_RST;
         next_first_axis_result = 13'h0000;
         next_second_axis_result = 13'h0000;
         next_third_axis_result = 15'h0000;
         next_plate_resistance_result = 14'h0000;
      end
      // Power bit cleared from sleep or active
      if (wr_ok && i_reg_addr == `MMPM_ADDR_POWER && !i_reg_wdata[`MMPM_PWR_BIT]
          && (state == MMPM_SLEEP || active)) begin
         next_state = MMPM_SUSPEND;
      end
      // Suspend keeps only power control and trim
      if (next_state == MMPM_SUSPEND) begin
         next_operation_select = `MMPM_OPSEL_RST;
         next_planar_repeats = `MMPM_REPEAT_RST;
         next_vertical_repeats = `MMPM_REPEAT_RST;
         next_first_axis_result = 13'h0000;
         next_second_axis_result = 13'h0000;
         next_third_axis_result = 15'h0000;
         next_plate_resistance_result = 14'h0000;
      end
      // Supply loss overrides everything
      if (!supplies_ok) begin
         next_state = MMPM_POWER_OFF;
         next_power_control = `MMPM_POWER_RST;
         next_operation_select = `MMPM_OPSEL_RST;
         next_planar_repeats = `MMPM_REPEAT_RST;
         next_vertical_repeats = `MMPM_REPEAT_RST;
         next_trim = `MMPM_TRIM_RST;
         next_first_axis_result = 13'h0000;
         next_second_axis_result = 13'h0000;
         next_third_axis_result = 15'h0000;
         next_plate_resistance_result = 14'h0000;
      end
      if (next_state != MMPM_NORMAL && next_state != MMPM_FORCED) begin
         meas_stop = 1'b1;
      end
      // Read answer
      next_rd_valid = i_reg_rd;
      next_rd_data = 8'h00;
      next_rd_drive = 1'b0;
      if (i_reg_rd) begin
         if (access_ok) begin
            next_rd_data = read_mux(i_reg_addr);
            next_rd_drive = 1'b1;
         end else begin
            next_rd_drive = !i_spi_mode;
         end
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         state <= MMPM_POWER_OFF;
         power_control <= `MMPM_POWER_RST;
         operation_select <= `MMPM_OPSEL_RST;
         planar_repeats <= `MMPM_REPEAT_RST;
         vertical_repeats <= `MMPM_REPEAT_RST;
         trim <= `MMPM_TRIM_RST;
         first_axis_result <= 13'h0000;
         second_axis_result <= 13'h0000;
         third_axis_result <= 15'h0000;
         plate_resistance_result <= 14'h0000;
         cnt <= 32'h00000000;
         o_rd_valid <= 1'b0;
         o_rd_data <= 8'h00;
         o_rd_drive <= 1'b0;
         o_state <= MMPM_POWER_OFF;
         o_spi3_wire <= 1'b0;
      end else begin
         state <= next_state;
         power_control <= next_power_control;
         operation_select <= next_operation_select;
         planar_repeats <= next_planar_repeats;
         vertical_repeats <= next_vertical_repeats;
         trim <= next_trim;
         first_axis_result <= next_first_axis_result;
         second_axis_result <= next_second_axis_result;
         third_axis_result <= next_third_axis_result;
         plate_resistance_result <= next_plate_resistance_result;
         cnt <= next_cnt;
         o_rd_valid <= next_rd_valid;
         o_rd_data <= next_rd_data;
         o_rd_drive <= next_rd_drive;
         o_state <= next_state;
         o_spi3_wire <= next_power_control[`MMPM_SPI3_BIT];
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_reset);

   sequence s_forced_trigger;
      state == MMPM_SLEEP && i_reg_wr && i_reg_addr == `MMPM_ADDR_OPSEL
         && i_reg_wdata[`MMPM_MODE_MSB:`MMPM_MODE_LSB] == MMPM_MODE_FORCED && supplies_ok;
   endsequence
   sequence s_forced_runs;
      state == MMPM_FORCED && meas_busy;
   endsequence

   a_off_until_supply: assert property (
      !supplies_ok |=> state == MMPM_POWER_OFF && power_control == `MMPM_POWER_RST)
      else $error("state not held off without both supplies");
   a_startup_loads: assert property (
      (state == MMPM_STARTUP && cnt == 32'(STARTUP_CYC - 1) && supplies_ok)
      |=> state == MMPM_SUSPEND && trim == $past(i_nvm_trim))
      else $error("start-up did not load trim and enter suspend");
   a_suspend_blocks: assert property (
      (state == MMPM_SUSPEND && i_reg_rd && i_reg_addr != `MMPM_ADDR_POWER)
      |=> o_rd_valid && o_rd_data == 8'h00)
      else $error("blocked register readable in suspend");
   a_suspend_clears: assert property (
      state == MMPM_SUSPEND |-> operation_select == `MMPM_OPSEL_RST
         && planar_repeats == `MMPM_REPEAT_RST && first_axis_result == 13'h0000)
      else $error("register kept contents in suspend");
   a_identity_undriven: assert property (
      (state == MMPM_SUSPEND && i_reg_rd && i_reg_addr == `MMPM_ADDR_IDENTITY)
      |=> o_rd_drive == !$past(i_spi_mode) && o_rd_data == 8'h00)
      else $error("identity read in suspend answered wrongly");
   a_wake_to_sleep: assert property (
      (state == MMPM_SUSPEND && i_reg_wr && i_reg_addr == `MMPM_ADDR_POWER
         && i_reg_wdata[`MMPM_PWR_BIT] && supplies_ok) |=> state == MMPM_SLEEP)
      else $error("power bit did not wake to sleep");
   a_mode_stop: assert property (
      (active && i_reg_wr && i_reg_addr == `MMPM_ADDR_OPSEL && supplies_ok
         && i_reg_wdata[`MMPM_MODE_MSB:`MMPM_MODE_LSB] == MMPM_MODE_SLEEP)
      |=> state == MMPM_SLEEP ##1 !meas_busy)
      else $error("stop write did not return to sleep");
   a_sleep_identity: assert property (
      (state == MMPM_SLEEP && i_reg_rd && i_reg_addr == `MMPM_ADDR_IDENTITY)
      |=> o_rd_drive && o_rd_data == IDENTITY)
      else $error("identity not readable in sleep");
   a_power_clear: assert property (
      ((state == MMPM_SLEEP || active) && i_reg_wr && i_reg_addr == `MMPM_ADDR_POWER
         && !i_reg_wdata[`MMPM_PWR_BIT] && supplies_ok) |=> state == MMPM_SUSPEND)
      else $error("power bit clear did not suspend");
   a_forced_start: assert property (
      s_forced_trigger |=> s_forced_runs)
      else $error("forced trigger did not start a measurement");
   a_normal_period: assert property (
      (state == MMPM_NORMAL && cnt >= period_lim - 32'h00000001 && !meas_stop)
      |=> meas_busy && cnt == 32'h00000000)
      else $error("normal period did not start a measurement");
   a_forced_return: assert property (
      (state == MMPM_FORCED && meas_done && supplies_ok && !i_reg_wr)
      |=> state == MMPM_SLEEP
         && operation_select[`MMPM_MODE_MSB:`MMPM_MODE_LSB] == MMPM_MODE_SLEEP)
      else $error("forced measurement did not fall back to sleep");
   a_retrigger_drop: assert property (
      (s_forced_runs ##0 meas_start) |=> !meas_done && $stable(first_axis_result))
      else $error("unfinished results were stored on retrigger");
   a_group_update: assert property (
      (meas_done && active && supplies_ok && !i_reg_wr)
      |=> first_axis_result == $past(i_field_x) && third_axis_result == $past(i_field_z)
         && plate_resistance_result == $past(i_plate_res))
      else $error("result set not stored together");
   a_blocked_write: assert property (
      (state == MMPM_SUSPEND && supplies_ok && i_reg_addr != `MMPM_ADDR_POWER)
      |=> state == MMPM_SUSPEND && $stable(power_control))
      else $error("blocked access disturbed suspend");

endmodule

/* core/mmpm_map.svh */
// Register offsets, field positions, reset values and timing for the magnetometer power control
`ifndef MMPM_MAP_SVH
`define MMPM_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define MMPM_ADDR_IDENTITY 8'h40
`define MMPM_ADDR_X_LO 8'h42
`define MMPM_ADDR_X_HI 8'h43
`define MMPM_ADDR_Y_LO 8'h44
`define MMPM_ADDR_Y_HI 8'h45
`define MMPM_ADDR_Z_LO 8'h46
`define MMPM_ADDR_Z_HI 8'h47
`define MMPM_ADDR_R_LO 8'h48
`define MMPM_ADDR_R_HI 8'h49
`define MMPM_ADDR_POWER 8'h4B
`define MMPM_ADDR_OPSEL 8'h4C
`define MMPM_ADDR_PLANAR 8'h51
`define MMPM_ADDR_VERTICAL 8'h52
`define MMPM_ADDR_TRIM 8'h5D

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MMPM_PWR_BIT 0
`define MMPM_SPI3_BIT 2
`define MMPM_SOFTRST_BIT 7
`define MMPM_MODE_LSB 1
`define MMPM_MODE_MSB 2
`define MMPM_RATE_LSB 3
`define MMPM_RATE_MSB 5

// ----------------------------------------
// Reset values
// ----------------------------------------
`define MMPM_POWER_RST 8'h00
`define MMPM_OPSEL_RST 8'h06
`define MMPM_REPEAT_RST 8'h01
`define MMPM_TRIM_RST 8'h00
`define MMPM_IDENTITY_VAL 8'h5A

// ----------------------------------------
// Timing, in ns
// ----------------------------------------
`define MMPM_CLK_NS 10
`define MMPM_T_STARTUP_NS 300000
`define MMPM_T_PLANAR_NS 145000
`define MMPM_T_VERTICAL_NS 500000
`define MMPM_T_BASE_NS 980000
`define MMPM_T_RATE_UNIT_NS 12500000

`endif

/* core/mmpm_pkg.sv */
// Types for the magnetometer power control
package mmpm_pkg;

   // ----------------------------------------
   // Power states
   // ----------------------------------------
   typedef enum logic [2:0] {
      MMPM_POWER_OFF = 3'b000,
      MMPM_STARTUP = 3'b001,
      MMPM_SUSPEND = 3'b010,
      MMPM_SLEEP = 3'b011,
      MMPM_NORMAL = 3'b100,
      MMPM_FORCED = 3'b101
   } mmpm_state_t;

   // ----------------------------------------
   // Measure mode field encodings
   // ----------------------------------------
   typedef enum logic [1:0] {
      MMPM_MODE_NORMAL = 2'b00,
      MMPM_MODE_FORCED = 2'b01,
      MMPM_MODE_RSVD = 2'b10,
      MMPM_MODE_SLEEP = 2'b11
   } mmpm_mode_t;

endpackage

/* core/mmpm_meas.sv */
// Measurement cycle timer of the magnetometer
`timescale 1ns/1ps
module mmpm_meas #(
   parameter int PLANAR_CYC = 14500,
   parameter int VERTICAL_CYC = 50000,
   parameter int BASE_CYC = 98000
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_reset,
   // Control
   input wire logic i_start,
   input wire logic i_stop,
   input wire logic [7:0] i_planar,
   input wire logic [7:0] i_vertical,
   // Status
   output logic o_busy,
   output logic o_done
);
   logic [31:0] cnt;
   logic [31:0] next_cnt;
   logic next_busy;
   logic next_done;
   logic [31:0] total;

   // ----------------------------------------
   // Cycle length and countdown
   // ----------------------------------------
   always_comb begin
      total = 32'(BASE_CYC) + 32'(PLANAR_CYC) * {24'h000000, i_planar}
            + 32'(VERTICAL_CYC) * {24'h000000, i_vertical};
      next_cnt = cnt;
      next_busy = o_busy;
      next_done = 1'b0;
      if (i_stop) begin
         next_busy = 1'b0;
      end else if (i_start) begin
         // Restart drops the unfinished cycle, no done for it
         next_cnt = total - 32'h00000001;
         next_busy = 1'b1;
      end else if (o_busy) begin
         if (cnt == 32'h00000000) begin
            next_busy = 1'b0;
            next_done = 1'b1;
         end else begin
            next_cnt = cnt - 32'h00000001;
         end
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         cnt <= 32'h00000000;
         o_busy <= 1'b0;
         o_done <= 1'b0;
      end else begin
         cnt <= next_cnt;
         o_busy <= next_busy;
         o_done <= next_done;
      end
   end

endmodule

/* dv/mmpm_front_model.sv */
// Sensor front end stand-in for the power control bench
`timescale 1ns/1ps
module mmpm_front_model (
   // Results
   output logic [12:0] o_field_x,
   output logic [12:0] o_field_y,
   output logic [14:0] o_field_z,
   output logic [13:0] o_plate_res
);
   // Fixed results so stored bytes are known
   assign o_field_x = 13'h0155;
   assign o_field_y = 13'h0AAA;
   assign o_field_z = 15'h1234;
   assign o_plate_res = 14'h0321;
endmodule

/* dv/tb_top.sv */
// Self-checking bench for the power control
`timescale 1ns/1ps
module tb_top;
   import mmpm_pkg::*;
   logic i_mclk = 1'b0;
   logic i_reset = 1'b1;
   logic core_ok = 1'b0;
   logic io_ok = 1'b0;
   logic [7:0] trim = 8'hC3;
   logic spi3;
   logic spi = 1'b0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic rd_valid;
   logic rd_drive;
   logic [7:0] rd_data;
   logic [12:0] fx;
   logic [12:0] fy;
   logic [14:0] fz;
   logic [13:0] fr;
   mmpm_state_t state;
   int n_fail = 0;
   int checks_done = 0;
   always #5 i_mclk = ~i_mclk;
   mmpm_front_model mmpm_front_model_i (.o_field_x(fx), .o_field_y(fy), .o_field_z(fz),
      .o_plate_res(fr));
   mmpm_top #(.STARTUP_CYC(8), .PLANAR_CYC(3), .VERTICAL_CYC(5), .BASE_CYC(10),
      .RATE_UNIT_CYC(100)) mmpm_top_i (.i_mclk(i_mclk), .i_reset(i_reset),
      .i_core_supply_ok(core_ok), .i_io_supply_ok(io_ok), .i_spi_mode(spi),
      .i_nvm_trim(trim), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
      .i_reg_wdata(wdata), .o_rd_valid(rd_valid), .o_rd_data(rd_data),
      .o_rd_drive(rd_drive), .i_field_x(fx), .i_field_y(fy), .i_field_z(fz),
      .i_plate_res(fr), .o_state(state), .o_spi3_wire(spi3));
   task automatic tally_and_finish();
      $display("checks %0d failures %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_mclk);
      wr = 1'b1;
      addr = a;
      wdata = d;
      @(negedge i_mclk);
      wr = 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(negedge i_mclk);
      rd = 1'b1;
      addr = a;
      @(negedge i_mclk);
      rd = 1'b0;
      chk("rd_valid", {7'h00, rd_valid}, 8'h01);
      chk("rd_data", rd_data, exp);
   endtask
   task automatic st_chk(input mmpm_state_t s);
      chk("state", {5'h00, state}, {5'h00, s});
   endtask
   task automatic wait_st(input mmpm_state_t s);
      int k;
      k = 0;
      while (state !== s && k < 60) begin
         @(negedge i_mclk);
         k++;
      end
   endtask
   initial begin
      #100000;
      n_fail++;
      tally_and_finish();
   end
   initial begin
      repeat (12) @(negedge i_mclk);
      i_reset = 1'b0;
      core_ok = 1'b1;
      repeat (4) @(negedge i_mclk);
      st_chk(MMPM_POWER_OFF);
      io_ok = 1'b1;
      wait_st(MMPM_SUSPEND);
      st_chk(MMPM_SUSPEND);
      rd_chk(8'h40, 8'h00);
      rd_chk(8'h5D, 8'h00);
      reg_wr(8'h4C, 8'h03);
      st_chk(MMPM_SUSPEND);
      reg_wr(8'h4B, 8'h01);
      st_chk(MMPM_SLEEP);
      rd_chk(8'h40, 8'h5A);
      rd_chk(8'h5D, 8'hC3);
      rd_chk(8'h4C, 8'h06);
      reg_wr(8'h51, 8'h03);
      reg_wr(8'h52, 8'h03);
      reg_wr(8'h4C, 8'h02);
      st_chk(MMPM_FORCED);
      rd_chk(8'h4B, 8'h01);
      wait_st(MMPM_SLEEP);
      st_chk(MMPM_SLEEP);
      rd_chk(8'h4C, 8'h06);
      rd_chk(8'h42, 8'hA8);
      rd_chk(8'h49, 8'h0C);
      reg_wr(8'h4C, 8'h02);
      reg_wr(8'h4C, 8'h02);
      repeat (33) @(negedge i_mclk);
      st_chk(MMPM_FORCED);
      repeat (2) @(negedge i_mclk);
      st_chk(MMPM_SLEEP);
      reg_wr(8'h4C, 8'h00);
      st_chk(MMPM_NORMAL);
      reg_wr(8'h4B, 8'h81);
      st_chk(MMPM_SLEEP);
      rd_chk(8'h42, 8'h00);
      reg_wr(8'h4C, 8'h38);
      repeat (120) @(negedge i_mclk);
      st_chk(MMPM_NORMAL);
      rd_chk(8'h42, 8'hA8);
      reg_wr(8'h4C, 8'h06);
      st_chk(MMPM_SLEEP);
      reg_wr(8'h51, 8'h07);
      reg_wr(8'h4B, 8'h04);
      st_chk(MMPM_SUSPEND);
      chk("spi3_wire", {7'h00, spi3}, 8'h01);
      rd_chk(8'h4B, 8'h04);
      spi = 1'b1;
      rd_chk(8'h40, 8'h00);
      chk("rd_drive", {7'h00, rd_drive}, 8'h00);
      spi = 1'b0;
      reg_wr(8'h4B, 8'h01);
      rd_chk(8'h51, 8'h01);
      io_ok = 1'b0;
      @(negedge i_mclk);
      st_chk(MMPM_POWER_OFF);
      tally_and_finish();
   end
endmodule
